// ==== core/adrc_ctrl.sv ====
// Host-side controller that runs read, early-write and column-before-row refresh cycles on a x4 DRAM
//
// What this block does
// - Wait power-up pause, then eight refreshes with write enable high before access.
// - Refresh every row within the refresh interval for the chosen row count.
// - Column strobe low before row strobe falls, held low after it falls.
// - Write enable stays high around the row strobe fall of a refresh.
// - Write enable fall only in early-write or read-modify-write window.
// - With output enable tied low, only reads and early writes are usable.
// - Write data valid from column strobe fall until hold time after.
// - Column strobe high a precharge time before a fresh cycle clears output.
// - Write enable stays high past column or row strobe rise to end reads.
// - Row strobe low at least its minimum and never beyond its maximum.
// - Random cycles start no closer than the random cycle time.
// - Hidden refresh keeps column strobe low and preserves last access data; this block never issues one.
// - Row-strobe-only refresh takes the row from address pins; write enable ignored; this block never issues one.
`timescale 1ns/10ps
`include "adrc_map.svh"
module adrc_ctrl
	import adrc_pkg::*;
#(
	parameter int unsigned ROW_BITS = `ADRC_ROW_BITS,
	parameter int unsigned PWRUP_NS = `ADRC_PWRUP_NS,
	parameter int unsigned RAS_MIN_NS = `ADRC_RAS_MIN_NS,
	parameter int unsigned RP_NS = `ADRC_RP_NS,
	parameter int unsigned RC_NS = `ADRC_RC_NS,
	parameter int unsigned RCD_MIN_NS = `ADRC_RCD_MIN_NS,
	parameter int unsigned RAC_NS = `ADRC_RAC_NS,
	parameter int unsigned CAS_MIN_NS = `ADRC_CAS_MIN_NS,
	parameter int unsigned CSR_NS = `ADRC_CSR_NS,
	parameter int unsigned CHR_NS = `ADRC_CHR_NS
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// Request port
	input wire logic i_req_valid,
	input wire adrc_req_t i_req,
	output logic o_req_ready,
	// Read answer and status
	output logic o_rd_valid,
	output logic [3:0] o_rd_data,
	output logic o_init_done,
	// DRAM pins
	output adrc_pins_t o_dram,
	input wire logic [3:0] i_dq_in
);

	////////////////////////////////////////////////////////////////////////////////
	// Cycle counts derived from the timing figures

	function automatic int unsigned cyc_min(input int unsigned ns);
		int unsigned c;
		c = (ns + `ADRC_CLK_NS - 1) / `ADRC_CLK_NS;
		return (c == 0) ? 1 : c;
	endfunction

	function automatic int unsigned max2(input int unsigned a, input int unsigned b);
		return (a > b) ? a : b;
	endfunction

	localparam int unsigned PWRUP_CYC = cyc_min(PWRUP_NS);
	localparam int unsigned RAS_CYC = cyc_min(RAS_MIN_NS);
	localparam int unsigned RP_CYC = cyc_min(RP_NS);
	localparam int unsigned RC_CYC = cyc_min(RC_NS);
	localparam int unsigned RCD_CYC = cyc_min(RCD_MIN_NS);
	localparam int unsigned RAC_CYC = cyc_min(RAC_NS);
	localparam int unsigned CAS_CYC = cyc_min(CAS_MIN_NS);
	localparam int unsigned CSR_CYC = cyc_min(CSR_NS);
	localparam int unsigned CHR_CYC = cyc_min(CHR_NS);
	localparam int unsigned WRH_CYC = cyc_min(`ADRC_WRH_NS);
	localparam int unsigned CPN_CYC = cyc_min(`ADRC_CPN_NS);
	localparam int unsigned RCD_MAX_CYC = `ADRC_RCD_MAX_NS / `ADRC_CLK_NS;
	// Column phase lengths keep the total row strobe low time at its minimum
	localparam int unsigned WCOL_CYC = max2(max2(CAS_CYC, RAS_CYC - RCD_CYC),
		max2(cyc_min(`ADRC_DH_NS), cyc_min(`ADRC_WCH_NS)));
	// Reads wait out the row access time plus the pin synchroniser
	localparam int unsigned RCOL_CYC = max2(max2(CAS_CYC, RAS_CYC - RCD_CYC),
		RAC_CYC - RCD_CYC) + `ADRC_SYNC_STAGES;
	localparam int unsigned RREF_CYC = max2(max2(RAS_CYC, CHR_CYC), WRH_CYC);
	localparam int unsigned PRE_CYC = max2(max2(RP_CYC, CPN_CYC), RC_CYC - RAS_CYC);
	localparam int unsigned REF_MS = (ROW_BITS == 12) ? `ADRC_REF_MS_12 : `ADRC_REF_MS_11;
	// Per-row spacing is a longest time, so it rounds down
	localparam int unsigned REFI_CYC = (REF_MS * 1000000 / (1 << ROW_BITS)) / `ADRC_CLK_NS;
	localparam int unsigned CW = `ADRC_CNT_W;

	if (ROW_BITS != 11 && ROW_BITS != 12) begin : g_param_check
		$error("adrc_ctrl: row address width must be 11 or 12");
	end
	// Every count has to fit the width shared by the two down-counters
	if (PWRUP_CYC >= (1 << CW) || REFI_CYC >= (1 << CW) || RCOL_CYC >= (1 << CW)) begin : g_width_check
		$error("adrc_ctrl: timing count too wide for the counter");
	end
	if (RCD_CYC > RCD_MAX_CYC) begin : g_rcd_check
		$error("adrc_ctrl: row to column delay beyond its maximum");
	end
	// Differences of the cycle counts are unsigned and must not wrap
	if (RAS_CYC < RCD_CYC || RC_CYC < RAS_CYC || RAC_CYC < RCD_CYC) begin : g_order_check
		$error("adrc_ctrl: timing figures out of order");
	end
	if (`ADRC_INIT_REFS > 15) begin : g_refs_check
		$error("adrc_ctrl: wake-up refresh count too wide");
	end

	////////////////////////////////////////////////////////////////////////////////
	// State

	adrc_state_t state_r, state_nxt;
	logic [CW-1:0] cnt_r, cnt_nxt;
	logic [CW-1:0] refi_r, refi_nxt;
	logic due_r, due_nxt;
	logic [3:0] refs_left_r, refs_left_nxt;
	logic [9:0] col_r, col_nxt;
	logic wr_r, wr_nxt;
	adrc_pins_t pins_r, pins_nxt;
	logic ready_r, ready_nxt;
	logic rd_valid_r, rd_valid_nxt;
	logic [3:0] rd_data_r, rd_data_nxt;
	logic init_done_r, init_done_nxt;
	logic [3:0] dq_s1_r, dq_s2_r, dq_s3_r;
	logic start_ref;
	logic tick;
	logic ref_served;

	assign o_req_ready = ready_r;
	assign o_rd_valid = rd_valid_r;
	assign o_rd_data = rd_data_r;
	assign o_init_done = init_done_r;
	assign o_dram = pins_r;

	////////////////////////////////////////////////////////////////////////////////
	// Next-state logic

	always_comb begin
		state_nxt = state_r;
		cnt_nxt = (cnt_r != '0) ? cnt_r - 1'b1 : cnt_r;
		refs_left_nxt = refs_left_r;
		col_nxt = col_r;
		wr_nxt = wr_r;
		pins_nxt = pins_r;
		rd_valid_nxt = 1'b0;
		rd_data_nxt = rd_data_r;
		start_ref = 1'b0;
		tick = (refi_r == '0);
		refi_nxt = tick ? CW'(REFI_CYC - 1) : refi_r - 1'b1;
		case (state_r)
			ST_INIT: begin
				if (cnt_r == '0) begin
					start_ref = 1'b1;
				end
			end
			ST_IDLE: begin
				if (due_r) begin
					start_ref = 1'b1;
				end else if (i_req_valid && ready_r) begin
					state_nxt = ST_ROW;
					cnt_nxt = CW'(RCD_CYC - 1);
					pins_nxt.ras_n = 1'b0;
					pins_nxt.addr = ROW_BITS == 12 ? i_req.row : {1'b0, i_req.row[10:0]};
					// Write enable settles before the column strobe falls, so every write is early
					pins_nxt.we_n = ~i_req.we;
					// Output enable kept high on writes; late writes are never issued
					pins_nxt.oe_n = i_req.we;
					pins_nxt.dq_out = i_req.wdata;
					pins_nxt.dq_oe = i_req.we;
					col_nxt = i_req.col;
					wr_nxt = i_req.we;
				end
			end
			ST_ROW: begin
				if (cnt_r == '0) begin
					state_nxt = ST_COL;
					cnt_nxt = wr_r ? CW'(WCOL_CYC - 1) : CW'(RCOL_CYC - 1);
					pins_nxt.cas_n = 1'b0;
					pins_nxt.addr = {2'h0, col_r};
				end
			end
			ST_COL: begin
				// Reads wait until the last two synchroniser stages agree
				if (cnt_r == '0 && (wr_r || dq_s2_r == dq_s3_r)) begin
					state_nxt = ST_PRE;
					cnt_nxt = CW'(PRE_CYC - 1);
					pins_nxt.ras_n = 1'b1;
					pins_nxt.cas_n = 1'b1;
					// Write enable returns high no earlier than the strobes rise
					pins_nxt.we_n = 1'b1;
					pins_nxt.oe_n = 1'b1;
					pins_nxt.dq_oe = 1'b0;
					rd_valid_nxt = ~wr_r;
					rd_data_nxt = wr_r ? rd_data_r : dq_s3_r;
				end
			end
			ST_PRE: begin
				// Precharge also spaces random cycles and gives the column strobe its high time
				if (cnt_r == '0) begin
					if (refs_left_r != '0) begin
						start_ref = 1'b1;
					end else begin
						state_nxt = ST_IDLE;
					end
				end
			end
			ST_RCAS: begin
				if (cnt_r == '0) begin
					state_nxt = ST_RRAS;
					cnt_nxt = CW'(RREF_CYC - 1);
					pins_nxt.ras_n = 1'b0;
				end
			end
			ST_RRAS: begin
				if (cnt_r == '0) begin
					state_nxt = ST_PRE;
					cnt_nxt = CW'(PRE_CYC - 1);
					pins_nxt.ras_n = 1'b1;
					pins_nxt.cas_n = 1'b1;
					// Wake-up run counts only completed refreshes
					if (refs_left_r != '0) begin
						refs_left_nxt = refs_left_r - 1'b1;
					end
				end
			end
			default: begin
				state_nxt = ST_INIT;
				cnt_nxt = CW'(PWRUP_CYC - 1);
			end
		endcase
		if (start_ref) begin
			// Column strobe leads the row strobe; write enable held high, address unused
			// Only this refresh form is issued, always from precharged strobes: no hidden or row-only refresh
			state_nxt = ST_RCAS;
			cnt_nxt = CW'(CSR_CYC - 1);
			pins_nxt.cas_n = 1'b0;
			pins_nxt.we_n = 1'b1;
			pins_nxt.oe_n = 1'b1;
			pins_nxt.dq_oe = 1'b0;
		end
		// Wake-up refreshes leave a pending interval tick to be served afterwards
		ref_served = start_ref && state_r != ST_PRE && state_r != ST_INIT;
		// A tick in the cycle a refresh starts is kept, so no interval is lost
		due_nxt = tick | (due_r & ~ref_served);
		init_done_nxt = (refs_left_nxt == '0);
		ready_nxt = (state_nxt == ST_IDLE) && !due_nxt && !start_ref;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			state_r <= ST_INIT;
			cnt_r <= CW'(PWRUP_CYC - 1);
			refi_r <= CW'(REFI_CYC - 1);
			due_r <= 1'b0;
			refs_left_r <= 4'(`ADRC_INIT_REFS);
			col_r <= 10'h000;
			wr_r <= 1'b0;
			pins_r <= '{
				ras_n: 1'b1,
				cas_n: 1'b1,
				we_n: 1'b1,
				oe_n: 1'b1,
				addr: 12'h000,
				dq_out: 4'h0,
				dq_oe: 1'b0
			};
			ready_r <= 1'b0;
			rd_valid_r <= 1'b0;
			rd_data_r <= 4'h0;
			init_done_r <= 1'b0;
			dq_s1_r <= 4'h0;
			dq_s2_r <= 4'h0;
			dq_s3_r <= 4'h0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			refi_r <= refi_nxt;
			due_r <= due_nxt;
			refs_left_r <= refs_left_nxt;
			col_r <= col_nxt;
			wr_r <= wr_nxt;
			pins_r <= pins_nxt;
			ready_r <= ready_nxt;
			rd_valid_r <= rd_valid_nxt;
			rd_data_r <= rd_data_nxt;
			init_done_r <= init_done_nxt;
			// Data pins are asynchronous: three stages, capture once the last two agree
			dq_s1_r <= i_dq_in;
			dq_s2_r <= dq_s1_r;
			dq_s3_r <= dq_s2_r;
		end
	end

endmodule

// ==== core/adrc_map.svh ====
// Timing figures and fixed counts for the asynchronous DRAM access and refresh controller
`ifndef ADRC_MAP_SVH
`define ADRC_MAP_SVH
`define ADRC_CLK_NS 10
`define ADRC_PWRUP_NS 100000
`define ADRC_INIT_REFS 8
`define ADRC_ROW_BITS 12
`define ADRC_REF_MS_11 32
`define ADRC_REF_MS_12 64
`define ADRC_RAS_MIN_NS 60
`define ADRC_RAS_MAX_NS 100000
`define ADRC_RP_NS 40
`define ADRC_RC_NS 110
`define ADRC_RCD_MIN_NS 20
`define ADRC_RCD_MAX_NS 45
`define ADRC_RAC_NS 60
`define ADRC_CAS_MIN_NS 15
`define ADRC_CPN_NS 10
`define ADRC_CSR_NS 5
`define ADRC_CHR_NS 15
`define ADRC_WRH_NS 10
`define ADRC_WCH_NS 10
`define ADRC_DH_NS 10
`define ADRC_SYNC_STAGES 3
`define ADRC_CNT_W 16
`endif

// ==== core/adrc_pkg.sv ====
// Types shared by the DRAM access and refresh controller
package adrc_pkg;
	typedef struct packed {
		logic we;
		logic [11:0] row;
		logic [9:0] col;
		logic [3:0] wdata;
	} adrc_req_t;

	typedef struct packed {
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic oe_n;
		logic [11:0] addr;
		logic [3:0] dq_out;
		logic dq_oe;
	} adrc_pins_t;

	typedef enum logic [6:0] {
		ST_INIT = 7'h01,
		ST_IDLE = 7'h02,
		ST_ROW = 7'h04,
		ST_COL = 7'h08,
		ST_PRE = 7'h10,
		ST_RCAS = 7'h20,
		ST_RRAS = 7'h40
	} adrc_state_t;
endpackage

// ==== bench/adrc_ctrl_asserts.sv ====
// Pin protocol checker for the DRAM access and refresh controller
`timescale 1ns/10ps
module adrc_ctrl_asserts
	import adrc_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// Request side
	input wire logic i_req_valid,
	input wire adrc_req_t i_req,
	input wire logic o_req_ready,
	input wire logic o_rd_valid,
	input wire logic [3:0] o_rd_data,
	input wire logic o_init_done,
	// DRAM pins
	input wire adrc_pins_t o_dram,
	input wire logic [3:0] i_dq_in
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_reset);
	////////////////////////////////////////
	cbr_setup_a: assert property ($fell(o_dram.ras_n) && !o_dram.cas_n |-> !$past(o_dram.cas_n))
		else $error("refresh column strobe late");
	cbr_hold_a: assert property ($fell(o_dram.ras_n) && !o_dram.cas_n |-> (!o_dram.cas_n)[*3])
		else $error("refresh column strobe hold short");
	cbr_we_high_a: assert property ($fell(o_dram.ras_n) && !o_dram.cas_n |-> $past(o_dram.we_n) && o_dram.we_n ##1 o_dram.we_n)
		else $error("write enable low around refresh");
	ras_min_a: assert property ($fell(o_dram.ras_n) |-> (!o_dram.ras_n)[*6])
		else $error("row strobe pulse short");
	cycle_time_a: assert property ($fell(o_dram.ras_n) |=> (!$fell(o_dram.ras_n))[*8] ##1 (!$fell(o_dram.ras_n))[*2])
		else $error("row cycles too close");
	row_col_gap_a: assert property ($fell(o_dram.ras_n) && o_dram.cas_n |-> o_dram.cas_n[*2] ##[1:3] !o_dram.cas_n)
		else $error("row to column delay out of range");
	early_wr_a: assert property ($fell(o_dram.cas_n) && !o_dram.we_n |-> !$past(o_dram.we_n) && o_dram.dq_oe
		##1 !o_dram.we_n && o_dram.dq_oe && $stable(o_dram.dq_out))
		else $error("early write timing broken");
	rd_we_hold_a: assert property ($rose(o_dram.cas_n) && $past(o_dram.we_n) |-> o_dram.we_n)
		else $error("read ended with write enable low");
	init_first_a: assert property ($fell(o_dram.cas_n) && !o_dram.ras_n |-> o_init_done)
		else $error("access before wake-up done");
	late_we_a: assert property ($fell(o_dram.we_n) |-> o_dram.cas_n)
		else $error("write enable fell with column strobe low");
	rd_answer_a: assert property ($fell(o_dram.cas_n) && !o_dram.ras_n && o_dram.we_n |-> ##[7:9] o_rd_valid)
		else $error("read answer missing");
endmodule

bind adrc_ctrl adrc_ctrl_asserts u_chk(.i_clk(i_clk), .i_reset(i_reset), .i_req_valid(i_req_valid), .i_req(i_req),
	.o_req_ready(o_req_ready), .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data), .o_init_done(o_init_done),
	.o_dram(o_dram), .i_dq_in(i_dq_in));

// ==== bench/adrc_dram_model.sv ====
// Behavioural x4 DRAM answering the controller strobes
`timescale 1ns/10ps
module adrc_dram_model
	import adrc_pkg::*;
(
	// Controller pins
	input wire adrc_pins_t i_pins,
	// Read data onto the data pins
	output logic [3:0] o_dq
);
	logic [3:0] mem [logic [21:0]];
	logic [11:0] row_r = 12'h000;
	logic [9:0] col_r = 10'h000;
	realtime t_ras = 0;
	realtime t_first_ras = 0;
	int refresh_cnt = 0;
	int test_mode_cnt = 0;
	int first_refs = -1;
	int late_wr_cnt = 0;
	initial o_dq = 4'h0;
	////////////////////////////////////////
	// Column strobe already low: internal row counter, outputs keep old data
	always @(negedge i_pins.ras_n) begin
		t_ras = $realtime;
		if (t_first_ras == 0) t_first_ras = t_ras;
		if (i_pins.cas_n) row_r = i_pins.addr;
		else begin
			refresh_cnt++;
			if (!i_pins.we_n) test_mode_cnt++;
		end
	end
	always @(negedge i_pins.cas_n) begin
		if (!i_pins.ras_n) begin
			col_r = i_pins.addr[9:0];
			if (first_refs < 0) first_refs = refresh_cnt;
			if (!i_pins.we_n) mem[{row_r, col_r}] = i_pins.dq_out;
			else begin
				// One ns late so data never lands on a clock edge
				#(1.0 + ((t_ras + 60.0 > $realtime + 15.0) ? t_ras + 60.0 - $realtime : 15.0));
				if (!i_pins.cas_n) o_dq = mem[{row_r, col_r}];
			end
		end
	end
	// Released pins float: show the inverse so a late sample is caught
	always @(posedge i_pins.cas_n) #15 o_dq = ~o_dq;
	// Write enable falling under a low column strobe would start a late or read-modify write
	always @(negedge i_pins.we_n) if (!i_pins.cas_n) late_wr_cnt++;
endmodule

// ==== bench/tb_top.sv ====
// Self-checking bench for the DRAM access and refresh controller
`timescale 1ns/10ps
module tb_top
	import adrc_pkg::*;
;
	localparam int PW = 200;
	logic i_clk, i_reset, i_req_valid, o_req_ready, o_rd_valid, o_init_done;
	adrc_req_t i_req;
	adrc_pins_t o_dram;
	logic [3:0] o_rd_data, dq_model, i_dq_in;
	logic [3:0] shadow [logic [21:0]];
	logic [3:0] expq [$];
	logic [31:0] seed = 32'hB478D833;
	int err_count = 0;
	int checks_done = 0;
	int cyc = 0;
	int cyc0;
	realtime t_rel;
	// Shared data pins: controller wins only while it drives
	assign i_dq_in = o_dram.dq_oe ? o_dram.dq_out : dq_model;
	adrc_ctrl #(.PWRUP_NS(PW)) DUT(.i_clk(i_clk), .i_reset(i_reset), .i_req_valid(i_req_valid), .i_req(i_req),
		.o_req_ready(o_req_ready), .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data), .o_init_done(o_init_done),
		.o_dram(o_dram), .i_dq_in(i_dq_in));
	adrc_dram_model u_dram(.i_pins(o_dram), .o_dq(dq_model));
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	////////////////////////////////////////
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks=%0d errors=%0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// Request stays up until a sampled ready; back-to-back keeps valid high
	task automatic issue(input logic we, input logic [3:0] k, input logic [3:0] d);
		adrc_req_t r;
		r = '{we, {6{k[1:0]}}, {5{k[3:2]}}, d};
		@(negedge i_clk);
		i_req_valid = 1'b1;
		i_req = r;
		// Ready is read off the edge; the rising edge after a high ready is the take
		while (o_req_ready !== 1'b1) @(negedge i_clk);
		@(posedge i_clk);
		if (we) shadow[{r.row, r.col}] = d;
		else expq.push_back(shadow[{r.row, r.col}]);
	endtask
	////////////////////////////////////////
	// Outputs are looked at on the falling edge, where they have settled
	always @(negedge i_clk) begin
		cyc++;
		if (cyc == 12000) begin
			err_count++;
			tally_and_finish();
		end else if (o_rd_valid === 1'b1) check(o_rd_data, expq.pop_front());
	end
	initial begin
		logic [31:0] v;
		i_reset = 1'b1;
		i_req_valid = 1'b0;
		i_req = '0;
		repeat (16) @(posedge i_clk);
		@(negedge i_clk);
		i_reset = 1'b0;
		t_rel = $realtime;
		for (int k = 0; k < 16; k++) issue(1'b1, 4'(k), 4'(xs()));
		cyc0 = cyc;
		check(o_init_done, 1);
		check(u_dram.first_refs, 8);
		check(u_dram.t_first_ras >= t_rel + PW, 1);
		for (int n = 0; n < 240; n++) begin
			v = xs();
			if (v[15:12] == 4'h0) begin
				@(negedge i_clk);
				i_req_valid = 1'b0;
				repeat (20) @(negedge i_clk);
			end
			issue(v[8], v[3:0], v[7:4]);
		end
		@(negedge i_clk);
		i_req_valid = 1'b0;
		repeat (40) @(posedge i_clk);
		check(expq.size(), 0);
		check(u_dram.late_wr_cnt, 0);
		check(u_dram.test_mode_cnt, 0);
		check(u_dram.refresh_cnt >= 8 + (cyc - cyc0 - 40) / 1562, 1);
		tally_and_finish();
	end
endmodule
